// *** common/wlm_params.svh ***
// Constants for the wake line manager: offsets, fields, reset values, timing
`ifndef WLM_PARAMS_SVH
`define WLM_PARAMS_SVH

`define WLM_OFF_CTRL        12'h000
`define WLM_OFF_MASK        12'h004
`define WLM_OFF_EDGE        12'h008
`define WLM_OFF_PEND        12'h00C
`define WLM_OFF_EXIT        12'h010
`define WLM_OFF_STAT        12'h014

`define WLM_CTRL_WAKE_BIT   0
`define WLM_CTRL_SRC_BIT    1
`define WLM_CTRL_STOP_BIT   2
`define WLM_EXIT_FLAG_BIT   0
`define WLM_STAT_STOP_BIT   0
`define WLM_STAT_RESTART_BIT 1

`define WLM_RST_WORD        32'h0000_0000
`define WLM_NUM_LINES       16

`define WLM_OSC_RESTART_NS  4000
`define WLM_CLK_PERIOD_NS   40

`endif

// *** common/wlm_pkg.sv ***
// Types shared by the wake line manager design
`default_nettype none
package wlm_pkg;
   typedef enum logic [2:0] {
      WLM_IDLE,
      WLM_ONE,
      WLM_ZERO,
      WLM_STOP,
      WLM_RESTART
   } wlm_seq_t;
endpackage : wlm_pkg
`default_nettype wire

// *** hdl/wlm_line.sv ***
// One wake line: edge detector and sticky pending flag
`default_nettype none
module wlm_line (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   input  wire logic pin,
   input  wire logic rise_sel,
   input  wire logic clr,
   output var  logic pend_q,
   output logic      hit
);
   logic armed_q;
   logic prev_q;

   // First sample after reset only primes the history, so a static level is no edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         armed_q <= 1'b0;
         prev_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         armed_q <= 1'b1;
         prev_q  <= pin;
      end
   end

   // Edges only, never levels
   assign hit = armed_q & (rise_sel ? (pin & ~prev_q) : (~pin & prev_q));

   // Set beats a simultaneous software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_q <= 1'b0;
      else if (clk_en)
      begin
         if (hit)
            pend_q <= 1'b1;
         else if (clr)
            pend_q <= 1'b0;
      end
   end
endmodule : wlm_line
`default_nettype wire

// *** hdl/wlm_top.sv ***
// Wake line manager: APB registers, line array, stop sequence and shared channel
`default_nettype none
`include "wlm_params.svh"
module wlm_top
   import wlm_pkg::*;
#(
   parameter int NLINES      = `WLM_NUM_LINES,
   parameter int RESTART_CYC = (`WLM_OSC_RESTART_NS + `WLM_CLK_PERIOD_NS - 1) / `WLM_CLK_PERIOD_NS
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              clk_en,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   input  wire logic [NLINES-1:0] wake_line_pin,
   input  wire logic              dedicated_irq_pin,
   input  wire logic              ext_stop_n,
   input  wire logic              irq_dma_ack,
   output var  logic              shared_ext_irq_channel,
   output var  logic              wake_event,
   output var  logic              stop_req
);

   // Elaboration checks: the read word and the restart counter bound these
   if (NLINES < 1 || NLINES > 32)
   begin : g_bad_nlines
      $error("wlm_top: NLINES must be 1 to 32");
   end
   if (RESTART_CYC < 1 || RESTART_CYC > 65535)
   begin : g_bad_restart
      $error("wlm_top: RESTART_CYC must be 1 to 65535");
   end

   logic              wake_mode_q;
   logic              src_sel_q;
   logic              stop_q;
   logic              exit_q;
   logic [NLINES-1:0] mask_q;
   logic [NLINES-1:0] edge_q;
   logic [NLINES-1:0] pend;
   logic [NLINES-1:0] hit;
   logic [NLINES-1:0] pend_clr;
   logic [15:0]       restart_q;
   wlm_seq_t          seq_q;

   logic              acc;
   logic              wr;
   logic              wr_ctrl;
   logic              addr_ok;
   logic [31:0]       rd_mux;
   logic              any_mask;
   logic              unmasked_pend;
   logic              wake_hit;
   logic              stop_ok;

   // APB: one wait state, write takes effect at the completing edge, read data is captured one edge earlier
   assign acc     = psel & penable & pready & clk_en;
   assign wr      = acc & pwrite;
   assign wr_ctrl = wr & (paddr == `WLM_OFF_CTRL);

   assign any_mask      = |mask_q;
   assign unmasked_pend = |(pend & mask_q);
   assign wake_hit      = wake_mode_q & unmasked_pend;
   assign stop_ok       = wake_mode_q & ~unmasked_pend & any_mask;

   genvar gi;
   generate
      for (gi = 0; gi < NLINES; gi++)
      begin : g_line
         assign pend_clr[gi] = wr & (paddr == `WLM_OFF_PEND) & ~pwdata[gi];
         wlm_line u_line (
            .pclk     (pclk),
            .presetn  (presetn),
            .clk_en   (clk_en),
            .pin      (wake_line_pin[gi]),
            .rise_sel (edge_q[gi]),
            .clr      (pend_clr[gi]),
            .pend_q   (pend[gi]),
            .hit      (hit[gi])
         );
      end
   endgenerate

   always_comb
   begin
      rd_mux  = `WLM_RST_WORD;
      addr_ok = 1'b1;
      case (paddr)
         `WLM_OFF_CTRL:
         begin
            rd_mux[`WLM_CTRL_WAKE_BIT] = wake_mode_q;
            rd_mux[`WLM_CTRL_SRC_BIT]  = src_sel_q;
            rd_mux[`WLM_CTRL_STOP_BIT] = stop_q;
         end
         `WLM_OFF_MASK: rd_mux[NLINES-1:0] = mask_q;
         `WLM_OFF_EDGE: rd_mux[NLINES-1:0] = edge_q;
         `WLM_OFF_PEND: rd_mux[NLINES-1:0] = pend;
         `WLM_OFF_EXIT: rd_mux[`WLM_EXIT_FLAG_BIT] = exit_q;
         `WLM_OFF_STAT:
         begin
            rd_mux[`WLM_STAT_STOP_BIT]    = (seq_q == WLM_STOP);
            rd_mux[`WLM_STAT_RESTART_BIT] = (seq_q == WLM_RESTART);
         end
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `WLM_RST_WORD;
      end
      else if (clk_en)
      begin
         if (psel && penable && !pready)
         begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok;
            prdata  <= pwrite ? `WLM_RST_WORD : rd_mux;
         end
         else
         begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // Plain configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_mode_q <= 1'b0;
         src_sel_q   <= 1'b0;
         mask_q      <= '0;
         edge_q      <= '0;
      end
      else if (wr)
      begin
         if (paddr == `WLM_OFF_CTRL)
         begin
            wake_mode_q <= pwdata[`WLM_CTRL_WAKE_BIT];
            src_sel_q   <= pwdata[`WLM_CTRL_SRC_BIT];
         end
         if (paddr == `WLM_OFF_MASK)
            mask_q <= pwdata[NLINES-1:0];
         if (paddr == `WLM_OFF_EDGE)
            edge_q <= pwdata[NLINES-1:0];
      end
   end

   // Stop sequence: any other register write or an acknowledge breaks it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_q     <= WLM_IDLE;
         stop_q    <= 1'b0;
         restart_q <= 16'h0000;
      end
      else if (clk_en)
      begin
         case (seq_q)
            WLM_IDLE:
            begin
               if (wr_ctrl && pwdata[`WLM_CTRL_STOP_BIT])
               begin
                  seq_q  <= WLM_ONE;
                  stop_q <= 1'b1;
               end
            end
            WLM_ONE, WLM_ZERO:
            begin
               if (irq_dma_ack || (wr && !wr_ctrl))
               begin
                  seq_q  <= WLM_IDLE;
                  stop_q <= 1'b0;
               end
               else if (wr_ctrl && seq_q == WLM_ONE)
               begin
                  seq_q  <= pwdata[`WLM_CTRL_STOP_BIT] ? WLM_ONE : WLM_ZERO;
                  stop_q <= pwdata[`WLM_CTRL_STOP_BIT];
               end
               else if (wr_ctrl)
               begin
                  // A wake event during the sequence leaves a pending flag and fails stop_ok
                  if (pwdata[`WLM_CTRL_STOP_BIT] && stop_ok)
                  begin
                     seq_q  <= WLM_STOP;
                     stop_q <= 1'b1;
                  end
                  else
                  begin
                     seq_q  <= WLM_IDLE;
                     stop_q <= 1'b0;
                  end
               end
            end
            WLM_STOP:
            begin
               if (wake_hit)
               begin
                  seq_q     <= WLM_RESTART;
                  stop_q    <= 1'b0;
                  restart_q <= 16'(RESTART_CYC - 1);
               end
            end
            WLM_RESTART:
            begin
               // Oscillator restart delay before the exit is reported
               if (restart_q == 16'h0000)
                  seq_q <= WLM_IDLE;
               else
                  restart_q <= restart_q - 16'h0001;
            end
            default:
            begin
               seq_q  <= WLM_IDLE;
               stop_q <= 1'b0;
            end
         endcase
      end
   end

   // Exit flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         exit_q <= 1'b0;
      else if (clk_en)
      begin
         if (seq_q == WLM_RESTART && restart_q == 16'h0000)
            exit_q <= 1'b1;
         else if ((seq_q == WLM_ONE || seq_q == WLM_ZERO) && irq_dma_ack)
            exit_q <= 1'b0;
         else if (wr && paddr == `WLM_OFF_EXIT && !pwdata[`WLM_EXIT_FLAG_BIT])
            exit_q <= 1'b0;
      end
   end

   // Outputs toward the CPU interrupt controller and clock controller
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shared_ext_irq_channel <= 1'b0;
         wake_event             <= 1'b0;
         stop_req               <= 1'b0;
      end
      else if (clk_en)
      begin
         // Level output; the CPU side triggers on its rising edge
         shared_ext_irq_channel <= src_sel_q ? unmasked_pend : dedicated_irq_pin;
         wake_event             <= wake_hit;
         stop_req               <= (seq_q == WLM_STOP) | ~ext_stop_n;
      end
   end

   property p_chan_src;
      @(posedge pclk) disable iff (!presetn)
      clk_en && !src_sel_q |=> shared_ext_irq_channel == $past(dedicated_irq_pin);
   endproperty
   a_chan_src: assert property (p_chan_src) else $error("channel not from pin");

   property p_chan_lines;
      @(posedge pclk) disable iff (!presetn)
      clk_en && src_sel_q && !(|(pend & mask_q)) |=> !shared_ext_irq_channel;
   endproperty
   a_chan_lines: assert property (p_chan_lines) else $error("channel raised with no unmasked pending");

   property p_first_write;
      @(posedge pclk) disable iff (!presetn)
      seq_q == WLM_IDLE && wr_ctrl && pwdata[`WLM_CTRL_STOP_BIT] |=> stop_q && seq_q == WLM_ONE;
   endproperty
   a_first_write: assert property (p_first_write) else $error("stop bit not 1 after first write");

   property p_enter_cond;
      @(posedge pclk) disable iff (!presetn)
      $changed(seq_q) && seq_q == WLM_STOP |-> $past(wake_mode_q) && $past(|mask_q) && !$past(|(pend & mask_q));
   endproperty
   a_enter_cond: assert property (p_enter_cond) else $error("stop entered without conditions");

   property p_ack_abort;
      @(posedge pclk) disable iff (!presetn)
      clk_en && irq_dma_ack && (seq_q == WLM_ONE || seq_q == WLM_ZERO)
      |=> seq_q == WLM_IDLE && !stop_q && !exit_q;
   endproperty
   a_ack_abort: assert property (p_ack_abort) else $error("acknowledge did not cancel stop");

   property p_stop_pin;
      @(posedge pclk) disable iff (!presetn)
      clk_en && !ext_stop_n |=> stop_req;
   endproperty
   a_stop_pin: assert property (p_stop_pin) else $error("stop pin did not force stop request");

   property p_wake_exit;
      @(posedge pclk) disable iff (!presetn)
      clk_en && seq_q == WLM_STOP && wake_hit |=> seq_q == WLM_RESTART && !stop_q ##1 !stop_req || !clk_en;
   endproperty
   a_wake_exit: assert property (p_wake_exit) else $error("wake event did not end stop");

   property p_exit_set;
      @(posedge pclk) disable iff (!presetn)
      $rose(exit_q) |-> $past(seq_q) == WLM_RESTART && seq_q == WLM_IDLE;
   endproperty
   a_exit_set: assert property (p_exit_set) else $error("exit flag set outside restart");

   property p_pend_set;
      @(posedge pclk) disable iff (!presetn)
      clk_en && hit[0] |=> pend[0];
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("edge did not set pending");

   property p_pend_clear;
      @(posedge pclk) disable iff (!presetn)
      pend_clr[0] && !hit[0] |=> !pend[0];
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared by write 0");
endmodule : wlm_top
`default_nettype wire

// *** verif/wlm_pin_model.sv ***
// Behavioural model of the external wake line pins
`default_nettype none
module wlm_pin_model #(
   parameter int NLINES = 16
) (
   input  wire logic              pclk,
   output var  logic [NLINES-1:0] wake_line_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial wake_line_pin = '0;

   // Levels move only just after a rising edge, like a synchronised source
   task automatic drive(input int idx, input logic lvl);
      @(posedge pclk);
      wake_line_pin[idx] <= lvl;
   endtask : drive
endmodule : wlm_pin_model
`default_nettype wire

// *** verif/wakeup_interrupt_line_manager_test.sv ***
// Self-checking testbench for the wake line manager
`default_nettype none
`include "wlm_params.svh"
module wakeup_interrupt_line_manager_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [11:0] a_ctrl = `WLM_OFF_CTRL;
   localparam logic [11:0] a_mask = `WLM_OFF_MASK;
   localparam logic [11:0] a_edge = `WLM_OFF_EDGE;
   localparam logic [11:0] a_pend = `WLM_OFF_PEND;
   localparam logic [11:0] a_exit = `WLM_OFF_EXIT;
   localparam logic [11:0] a_stat = `WLM_OFF_STAT;

   logic        pclk;
   logic        presetn;
   logic        clk_en;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] wake_line_pin;
   logic        dedicated_irq_pin;
   logic        ext_stop_n;
   logic        irq_dma_ack;
   logic        shared_ext_irq_channel;
   logic        wake_event;
   logic        stop_req;
   int          num_errors = 0;
   int          checks_done = 0;

   // Short restart count keeps stop exits quick
   wlm_top #(.NLINES(16), .RESTART_CYC(2)) i_dut (
      .pclk                   (pclk),
      .presetn                (presetn),
      .clk_en                 (clk_en),
      .psel                   (psel),
      .penable                (penable),
      .pwrite                 (pwrite),
      .paddr                  (paddr),
      .pwdata                 (pwdata),
      .prdata                 (prdata),
      .pready                 (pready),
      .pslverr                (pslverr),
      .wake_line_pin          (wake_line_pin),
      .dedicated_irq_pin      (dedicated_irq_pin),
      .ext_stop_n             (ext_stop_n),
      .irq_dma_ack            (irq_dma_ack),
      .shared_ext_irq_channel (shared_ext_irq_channel),
      .wake_event             (wake_event),
      .stop_req               (stop_req)
   );

   wlm_pin_model #(.NLINES(16)) i_pins (
      .pclk          (pclk),
      .wake_line_pin (wake_line_pin)
   );

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic give_verdict;
      $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_b(input logic got, input logic exp);
      chk_w({31'h0, got}, {31'h0, exp});
   endtask : chk_b

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // Master holds the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         num_errors++;
         give_verdict();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk_w(r, exp);
   endtask : rd

   task automatic seq(input logic [31:0] c);
      wr(a_ctrl, c | 32'h0000_0004);
      wr(a_ctrl, c);
      wr(a_ctrl, c | 32'h0000_0004);
   endtask : seq

   task automatic t_reset;
      logic [31:0] r;
      logic        e;
      for (int i = 0; i < 6; i++)
      begin
         rd(12'(4 * i), 32'h0000_0000);
      end
      apb(1'b0, 12'h0fc, 32'h0000_0000, r, e);
      chk_b(e, 1'b1);
      chk_b(stop_req, 1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_irq;
      wr(a_mask, 32'h0000_0001);
      wr(a_edge, 32'h0000_0003);
      wr(a_ctrl, 32'h0000_0002);
      i_pins.drive(1, 1'b1);
      cyc(4);
      chk_b(shared_ext_irq_channel, 1'b0);
      i_pins.drive(0, 1'b1);
      cyc(4);
      chk_b(shared_ext_irq_channel, 1'b1);
      chk_b(wake_event, 1'b0);
      // Line 0 stays high while its flag is cleared
      wr(a_pend, 32'h0000_0000);
      cyc(2);
      chk_b(shared_ext_irq_channel, 1'b0);
      rd(a_pend, 32'h0000_0000);
      i_pins.drive(0, 1'b0);
      i_pins.drive(1, 1'b0);
      cyc(4);
      rd(a_pend, 32'h0000_0000);
      dedicated_irq_pin <= 1'b1;
      cyc(4);
      chk_b(shared_ext_irq_channel, 1'b0);
      wr(a_ctrl, 32'h0000_0000);
      cyc(2);
      chk_b(shared_ext_irq_channel, 1'b1);
      dedicated_irq_pin <= 1'b0;
      $display("test interrupt mode done");
   endtask : t_irq

   task automatic t_wake_fall;
      wr(a_mask, 32'h0000_8000);
      wr(a_edge, 32'h0000_0000);
      wr(a_ctrl, 32'h0000_0001);
      i_pins.drive(15, 1'b1);
      cyc(4);
      rd(a_pend, 32'h0000_0000);
      i_pins.drive(15, 1'b0);
      cyc(4);
      chk_b(wake_event, 1'b1);
      chk_b(shared_ext_irq_channel, 1'b0);
      rd(a_pend, 32'h0000_8000);
      wr(a_pend, 32'h0000_0000);
      $display("test falling wake done");
   endtask : t_wake_fall

   task automatic t_stop_ok;
      wr(a_mask, 32'h0000_0001);
      wr(a_edge, 32'h0000_0001);
      seq(32'h0000_0001);
      cyc(2);
      chk_b(stop_req, 1'b1);
      rd(a_ctrl, 32'h0000_0005);
      rd(a_stat, 32'h0000_0001);
      i_pins.drive(0, 1'b1);
      cyc(8);
      chk_b(stop_req, 1'b0);
      rd(a_ctrl, 32'h0000_0001);
      rd(a_exit, 32'h0000_0001);
      cyc(4);
      rd(a_exit, 32'h0000_0001);
      wr(a_pend, 32'h0000_0000);
      i_pins.drive(0, 1'b0);
      $display("test stop entry and exit done");
   endtask : t_stop_ok

   // Exit flag is still set here, so the abort must clear it
   task automatic t_abort;
      wr(a_ctrl, 32'h0000_0005);
      irq_dma_ack <= 1'b1;
      cyc(1);
      irq_dma_ack <= 1'b0;
      rd(a_ctrl, 32'h0000_0001);
      rd(a_exit, 32'h0000_0000);
      wr(a_ctrl, 32'h0000_0001);
      wr(a_ctrl, 32'h0000_0005);
      cyc(2);
      chk_b(stop_req, 1'b0);
      wr(a_ctrl, 32'h0000_0001);
      wr(a_edge, 32'h0000_0001);
      wr(a_ctrl, 32'h0000_0005);
      cyc(2);
      chk_b(stop_req, 1'b0);
      wr(a_mask, 32'h0000_0001);
      rd(a_ctrl, 32'h0000_0001);
      $display("test aborted sequence done");
   endtask : t_abort

   task automatic t_wake_mid;
      wr(a_ctrl, 32'h0000_0005);
      wr(a_ctrl, 32'h0000_0001);
      i_pins.drive(0, 1'b1);
      cyc(4);
      wr(a_ctrl, 32'h0000_0005);
      cyc(2);
      chk_b(stop_req, 1'b0);
      rd(a_ctrl, 32'h0000_0001);
      rd(a_exit, 32'h0000_0000);
      rd(a_pend, 32'h0000_0001);
      wr(a_pend, 32'h0000_0000);
      i_pins.drive(0, 1'b0);
      $display("test wake during sequence done");
   endtask : t_wake_mid

   task automatic t_cond;
      wr(a_mask, 32'h0000_0000);
      seq(32'h0000_0001);
      cyc(2);
      chk_b(stop_req, 1'b0);
      rd(a_ctrl, 32'h0000_0001);
      wr(a_mask, 32'h0000_0001);
      seq(32'h0000_0000);
      cyc(2);
      chk_b(stop_req, 1'b0);
      rd(a_ctrl, 32'h0000_0000);
      $display("test entry conditions done");
   endtask : t_cond

   task automatic t_ext_stop;
      ext_stop_n <= 1'b0;
      cyc(3);
      chk_b(stop_req, 1'b1);
      ext_stop_n <= 1'b1;
      cyc(3);
      chk_b(stop_req, 1'b0);
      $display("test external stop pin done");
   endtask : t_ext_stop

   // Clock enable low must freeze the channel register as well
   task automatic t_freeze;
      clk_en <= 1'b0;
      dedicated_irq_pin <= 1'b1;
      cyc(3);
      chk_b(shared_ext_irq_channel, 1'b0);
      clk_en <= 1'b1;
      cyc(3);
      chk_b(shared_ext_irq_channel, 1'b1);
      dedicated_irq_pin <= 1'b0;
      $display("test clock enable freeze done");
   endtask : t_freeze

   initial
   begin
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      dedicated_irq_pin = 1'b0;
      ext_stop_n = 1'b1;
      irq_dma_ack = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_irq();
      t_wake_fall();
      t_stop_ok();
      t_abort();
      t_wake_mid();
      t_cond();
      t_ext_stop();
      t_freeze();
      give_verdict();
   end
endmodule : wakeup_interrupt_line_manager_test
`default_nettype wire
